// File: inc/ovs_pkg.sv
package ovs_pkg;
   // Setpoints in millivolts
   localparam int          MV_W           = 12;
   localparam logic [11:0] MV_STRAP_SHORT = 12'h3E8;
   localparam logic [11:0] MV_STRAP_OPEN  = 12'h4B0;
   localparam int          STRAP_CODES    = 22;
   localparam logic [4:0]  STRAP_CODE_SHORT = 5'h00;
   localparam logic [4:0]  STRAP_CODE_OPEN  = 5'h15;
   // Percent figures
   localparam int          PCT_MARGIN     = 5;
   localparam int          PCT_CLAMP      = 115;
   localparam int          PCT_OV         = 115;
   localparam int          PCT_UV         = 85;
   localparam int          PCT_PG_ON      = 90;
   // Timing
   localparam int          CLK_HZ         = 10_000_000;
   localparam int          HICCUP_MS      = 10;
   localparam int          HICCUP_CYC     = CLK_HZ / 1000 * HICCUP_MS;
   localparam int          PG_DELAY_US    = 1000;
   localparam int          PG_DELAY_CYC   = CLK_HZ / 1_000_000 * PG_DELAY_US;
   // AHB register byte offsets
   localparam logic [7:0]  OFS_OPERATION  = 8'h00;
   localparam logic [7:0]  OFS_ONOFF_CFG  = 8'h04;
   localparam logic [7:0]  OFS_VOUT_CMD   = 8'h08;
   localparam logic [7:0]  OFS_VOUT_TRIM  = 8'h0C;
   localparam logic [7:0]  OFS_MARGIN_HI  = 8'h10;
   localparam logic [7:0]  OFS_MARGIN_LO  = 8'h14;
   localparam logic [7:0]  OFS_VOUT_MAX   = 8'h18;
   localparam logic [7:0]  OFS_OV_LIMIT   = 8'h1C;
   localparam logic [7:0]  OFS_UV_LIMIT   = 8'h20;
   localparam logic [7:0]  OFS_PG_ON      = 8'h24;
   localparam logic [7:0]  OFS_PG_DELAY   = 8'h28;
   localparam logic [7:0]  OFS_FAULT_CFG  = 8'h2C;
   localparam logic [7:0]  OFS_CLEAR      = 8'h30;
   localparam logic [7:0]  OFS_STATUS     = 8'h34;
   localparam logic [7:0]  OFS_TARGET     = 8'h38;
   // Field positions
   localparam int          OP_ON_BIT      = 7;
   localparam int          OP_MHI_BIT     = 5;
   localparam int          OP_MLO_BIT     = 4;
   localparam int          CFG_PIN_EN_BIT = 0;
   localparam int          CFG_BUS_EN_BIT = 1;
   localparam int          CFG_POL_HI_BIT = 2;
   localparam int          CFG_SSTOP_BIT  = 3;
   localparam int          FC_OV_LATCH    = 0;
   localparam int          FC_UV_LATCH    = 1;
   localparam int          FC_SHARE       = 2;
   localparam int          FC_PUSHPULL    = 3;
   localparam logic [3:0]  ONOFF_RST      = 4'h7;

   typedef enum logic [2:0] {
      OVS_INIT  = 3'b000,
      OVS_OFF   = 3'b001,
      OVS_RAMP  = 3'b010,
      OVS_RUN   = 3'b011,
      OVS_LATCH = 3'b100,
      OVS_HICC  = 3'b101,
      OVS_STOP  = 3'b110
   } ovs_state_t;

   typedef struct packed {
      logic        pg_o;
      logic        pg_oe;
   } ovs_pg_t;
endpackage

// File: hdl/ovs_top.sv
// Notes on behaviour
// - Output enabled by pin; OPERATION also required when bus enable set
// - Pin polarity set in ON_OFF_CONFIG
// - Strap maps to fixed setpoint table
// - Strap sampled once at initialization
// - VOUT_COMMAND overrides strap, clamp applies
// - Margin high/low, default plus minus 5%
// - Margin works for either enable source
// - Signed trim added to commanded setpoint
// - Output clamped to 115% strap setpoint
// - Stored setpoint reads back unclamped
// - VOUT_MAX only lowers the clamp
// - OV limit default 115%, configurable response
// - Latched fault stays off until cleared or re-enabled
// - Hiccup fault retries at fixed interval
// - Default fault response is hiccup
// - Current sharing forces latched response
// - UV limit default 85%, same responses
// - Power good low in ramp, fault
// - Power good on 90%, off 85%
// - Power good waits programmable delay
// - Power good open-drain, push-pull option
// - Power good driven low before initialization
// - Soft-stop only when configured
//
// Local design decisions: the register addresses and register access over AHB-Lite.
module ovs_top
   import ovs_pkg::*;
#(
   parameter int HICCUP_CYCLES = HICCUP_CYC
) (
   // System
   input  wire logic        CLK_SYS,
   input  wire logic        ARST_N,
   // AHB-Lite slave
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output logic      [31:0] HRDATA,
   output logic             HREADYOUT,
   output logic             HRESP,
   // Pins and analogue front end
   input  wire logic        ENABLE_PIN,
   input  wire logic [4:0]  SETPOINT_STRAP_CODE,
   input  wire logic [11:0] VOUT_SENSE_MV,
   input  wire logic        RAMP_DONE,
   output logic             REGULATE,
   output logic [11:0]      TARGET_MV,
   output logic             SOFT_STOP,
   output ovs_pkg::ovs_pg_t POWER_GOOD_OUTPUT
);
   import ovs_pkg::*;

   function automatic logic [11:0] pct(input logic [11:0] v, input int p);
      logic [31:0] t;
      t = 32'(v) * 32'(p) / 32'd100;
      return t[11:0];
   endfunction

   function automatic logic [11:0] strap_mv(input logic [4:0] c);
      case (c)
         5'h00: return MV_STRAP_SHORT;
         5'h01: return 12'h258;  5'h02: return 12'h28A;  5'h03: return 12'h2BC;
         5'h04: return 12'h2EE;  5'h05: return 12'h320;  5'h06: return 12'h352;
         5'h07: return 12'h384;  5'h08: return 12'h3B6;  5'h09: return 12'h3E8;
         5'h0A: return 12'h41A;  5'h0B: return 12'h44C;  5'h0C: return 12'h47E;
         5'h0D: return 12'h4B0;  5'h0E: return 12'h4E2;  5'h0F: return 12'h514;
         5'h10: return 12'h578;  5'h11: return 12'h5DC;  5'h12: return 12'h640;
         5'h13: return 12'h6A4;  5'h14: return 12'h708;
         default: return MV_STRAP_OPEN;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Synchronisers
   logic       en_s1_reg, en_s2_reg;
   logic [4:0] strap_s1_reg, strap_s2_reg;
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         en_s1_reg    <= 1'b0;
         en_s2_reg    <= 1'b0;
      end else begin
         en_s1_reg    <= ENABLE_PIN;
         en_s2_reg    <= en_s1_reg;
      end
   end

   // No reset: the strap must be through both flops by the first edge after release
   always_ff @(posedge CLK_SYS) begin
      strap_s1_reg <= SETPOINT_STRAP_CODE;
      strap_s2_reg <= strap_s1_reg;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   logic [7:0]  operation_reg;
   logic [3:0]  onoff_reg;
   logic [11:0] vcmd_reg, mhi_reg, mlo_reg, vmax_reg, ov_reg, uv_reg, pgon_reg;
   logic [15:0] trim_reg;
   logic [23:0] pgdly_reg;
   logic [3:0]  fcfg_reg;
   logic [11:0] strap_reg;
   logic        init_done_reg, clear_reg, was_en_reg;
   logic        wr_pend_reg;
   logic [7:0]  wr_addr_reg;
   ovs_state_t  state_reg;
   logic [31:0] cnt_reg;
   logic        pg_reg, pg_arm_reg;
   logic        ov_seen_reg, uv_seen_reg;

   wire addr_ph = HSEL && HREADY && HTRANS[1];
   wire [11:0] wv = HWDATA[11:0];

   // Strap caught once after reset release; defaults derive from it
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         init_done_reg <= 1'b0;
         strap_reg     <= MV_STRAP_SHORT;
      end else if (!init_done_reg) begin
         init_done_reg <= 1'b1;
         strap_reg     <= strap_mv(strap_s2_reg);
      end
   end

   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
      end else begin
         wr_pend_reg <= addr_ph && HWRITE;
         if (addr_ph) begin
            wr_addr_reg <= HADDR[7:0];
         end
      end
   end

   wire init_pulse = init_done_reg && (state_reg == OVS_INIT);

   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         operation_reg <= 8'h00;
         onoff_reg     <= ONOFF_RST;
         vcmd_reg <= 12'h000; mhi_reg <= 12'h000; mlo_reg <= 12'h000;
         vmax_reg <= 12'hFFF; ov_reg  <= 12'h000; uv_reg  <= 12'h000;
         pgon_reg <= 12'h000;
         trim_reg      <= 16'h0000;
         pgdly_reg     <= 24'(PG_DELAY_CYC);
         fcfg_reg      <= 4'h0;
         clear_reg     <= 1'b0;
      end else if (init_pulse) begin
         vcmd_reg <= strap_reg;
         mhi_reg  <= pct(strap_reg, 100 + PCT_MARGIN);
         mlo_reg  <= pct(strap_reg, 100 - PCT_MARGIN);
         ov_reg   <= pct(strap_reg, PCT_OV);
         uv_reg   <= pct(strap_reg, PCT_UV);
         pgon_reg <= pct(strap_reg, PCT_PG_ON);
         vmax_reg <= 12'hFFF;
      end else begin
         clear_reg <= wr_pend_reg && (wr_addr_reg == OFS_CLEAR);
         if (wr_pend_reg) begin
            case (wr_addr_reg)
               OFS_OPERATION: operation_reg <= HWDATA[7:0];
               OFS_ONOFF_CFG: onoff_reg     <= HWDATA[3:0];
               OFS_VOUT_CMD:  vcmd_reg      <= wv;
               OFS_VOUT_TRIM: trim_reg      <= HWDATA[15:0];
               OFS_MARGIN_HI: mhi_reg       <= wv;
               OFS_MARGIN_LO: mlo_reg       <= wv;
               OFS_VOUT_MAX:  vmax_reg      <= wv;
               OFS_OV_LIMIT:  ov_reg        <= wv;
               OFS_UV_LIMIT:  uv_reg        <= wv;
               OFS_PG_ON:     pgon_reg      <= wv;
               OFS_PG_DELAY:  pgdly_reg     <= HWDATA[23:0];
               OFS_FAULT_CFG: fcfg_reg      <= HWDATA[3:0];
               default: ;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Setpoint path
   wire pin_on  = onoff_reg[CFG_PIN_EN_BIT] &&
                  (en_s2_reg == onoff_reg[CFG_POL_HI_BIT]);
   wire bus_on  = !onoff_reg[CFG_BUS_EN_BIT] || operation_reg[OP_ON_BIT];
   wire want_on = init_done_reg && pin_on && bus_on &&
                  (onoff_reg[CFG_PIN_EN_BIT] || onoff_reg[CFG_BUS_EN_BIT]);
   wire [11:0] nominal = operation_reg[OP_MHI_BIT] ? mhi_reg :
                         operation_reg[OP_MLO_BIT] ? mlo_reg : vcmd_reg;
   // One spare bit so a large positive trim cannot wrap to a negative sum
   wire signed [14:0] sum = $signed({3'b000, nominal}) + 15'($signed(trim_reg[13:0]));
   wire [11:0] hw_cap = pct(strap_reg, PCT_CLAMP);
   wire [11:0] cap    = (vmax_reg < hw_cap) ? vmax_reg : hw_cap;
   wire [11:0] sum_u  = sum[14] ? 12'h000 : (|sum[13:12] ? 12'hFFF : sum[11:0]);
   wire [11:0] target = (sum_u > cap) ? cap : sum_u;

   ////////////////////////////////////////////////////////////////////////////
   // Control state machine
   wire ov_hit  = VOUT_SENSE_MV > ov_reg;
   wire uv_hit  = (state_reg == OVS_RUN) && (VOUT_SENSE_MV < uv_reg);
   wire latch_m = fcfg_reg[FC_SHARE] ||
                  (ov_hit ? fcfg_reg[FC_OV_LATCH] : fcfg_reg[FC_UV_LATCH]);
   wire fault   = (state_reg == OVS_RAMP || state_reg == OVS_RUN) && (ov_hit || uv_hit);

   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         state_reg  <= OVS_INIT;
         cnt_reg    <= 32'h0000_0000;
         was_en_reg <= 1'b0;
      end else begin
         was_en_reg <= want_on;
         case (state_reg)
            OVS_INIT: if (init_done_reg) state_reg <= OVS_OFF;
            OVS_OFF: if (want_on) state_reg <= OVS_RAMP;
            OVS_RAMP, OVS_RUN: begin
               if (fault) begin
                  state_reg <= latch_m ? OVS_LATCH : OVS_HICC;
                  cnt_reg   <= 32'h0000_0000;
               end else if (!want_on) begin
                  state_reg <= onoff_reg[CFG_SSTOP_BIT] ? OVS_STOP : OVS_OFF;
               end else if (state_reg == OVS_RAMP && RAMP_DONE) begin
                  state_reg <= OVS_RUN;
               end
            end
            OVS_LATCH:
               if (clear_reg || (want_on && !was_en_reg) || !want_on) state_reg <= OVS_OFF;
            OVS_HICC: begin
               if (!want_on) state_reg <= OVS_OFF;
               else if (cnt_reg >= 32'(HICCUP_CYCLES - 1)) state_reg <= OVS_RAMP;
               cnt_reg <= cnt_reg + 32'h0000_0001;
            end
            OVS_STOP: if (RAMP_DONE || want_on) state_reg <= want_on ? OVS_RAMP : OVS_OFF;
            default: state_reg <= OVS_OFF;
         endcase
      end
   end

   // Fault history for status readback; set wins over clear
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         ov_seen_reg <= 1'b0;
         uv_seen_reg <= 1'b0;
      end else begin
         ov_seen_reg <= (fault && ov_hit) || (ov_seen_reg && !clear_reg);
         uv_seen_reg <= (fault && uv_hit && !ov_hit) || (uv_seen_reg && !clear_reg);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Power good: hysteresis between on level and UV level, then delay
   logic [23:0] pg_cnt_reg;
   wire cnt_pg_done = pg_cnt_reg >= pgdly_reg;
   // Gated so the pin falls with REGULATE on a fault or on a disable without soft-stop
   wire pg_now      = pg_reg && (state_reg == OVS_RUN) && !fault;
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         pg_arm_reg <= 1'b0;
         pg_reg     <= 1'b0;
      end else if (state_reg != OVS_RUN || fault) begin
         pg_arm_reg <= 1'b0;
         pg_reg     <= 1'b0;
      end else if (VOUT_SENSE_MV < uv_reg) begin
         pg_arm_reg <= 1'b0;
         pg_reg     <= 1'b0;
      end else if (!pg_arm_reg && VOUT_SENSE_MV > pgon_reg) begin
         pg_arm_reg <= 1'b1;
      end else if (pg_arm_reg && !pg_reg && cnt_pg_done) begin
         pg_reg     <= 1'b1;
      end
   end

   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) pg_cnt_reg <= 24'h000000;
      else if (!pg_arm_reg) pg_cnt_reg <= 24'h000000;
      else if (!cnt_pg_done) pg_cnt_reg <= pg_cnt_reg + 24'h000001;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs and read data
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         REGULATE          <= 1'b0;
         TARGET_MV         <= 12'h000;
         SOFT_STOP         <= 1'b0;
         POWER_GOOD_OUTPUT <= '{pg_o: 1'b0, pg_oe: 1'b1};
      end else begin
         REGULATE  <= (state_reg == OVS_RAMP || state_reg == OVS_RUN ||
                       state_reg == OVS_STOP) && !fault;
         TARGET_MV <= target;
         SOFT_STOP <= state_reg == OVS_STOP;
         // Open drain drives only the low level
         POWER_GOOD_OUTPUT.pg_o  <= pg_now;
         POWER_GOOD_OUTPUT.pg_oe <= fcfg_reg[FC_PUSHPULL] || !pg_now;
      end
   end

   logic [31:0] rdata;
   // Decoded in the address phase so the word stands in the data phase
   always_comb begin
      case (HADDR[7:0])
         OFS_OPERATION: rdata = {24'h0, operation_reg};
         OFS_ONOFF_CFG: rdata = {28'h0, onoff_reg};
         OFS_VOUT_CMD:  rdata = {20'h0, vcmd_reg};
         OFS_VOUT_TRIM: rdata = {16'h0, trim_reg};
         OFS_MARGIN_HI: rdata = {20'h0, mhi_reg};
         OFS_MARGIN_LO: rdata = {20'h0, mlo_reg};
         OFS_VOUT_MAX:  rdata = {20'h0, vmax_reg};
         OFS_OV_LIMIT:  rdata = {20'h0, ov_reg};
         OFS_UV_LIMIT:  rdata = {20'h0, uv_reg};
         OFS_PG_ON:     rdata = {20'h0, pgon_reg};
         OFS_PG_DELAY:  rdata = {8'h0, pgdly_reg};
         OFS_FAULT_CFG: rdata = {28'h0, fcfg_reg};
         OFS_STATUS:    rdata = {24'h0, ov_seen_reg, uv_seen_reg, pg_reg, REGULATE,
                                 1'b0, state_reg};
         OFS_TARGET:    rdata = {20'h0, TARGET_MV};
         default:       rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         HRDATA    <= 32'h0000_0000;
         HREADYOUT <= 1'b1;
         HRESP     <= 1'b0;
      end else begin
         if (addr_ph && !HWRITE) begin
            HRDATA <= rdata;
         end
         HREADYOUT <= 1'b1;
         HRESP     <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   sequence s_fault_hit;
      fault;
   endsequence
   a_fault_kills_reg: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      s_fault_hit |=> !REGULATE) else $error("regulation after fault");
   a_share_latches: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      (fault && fcfg_reg[FC_SHARE]) |=> state_reg == OVS_LATCH) else $error("no latch");
   a_latch_holds: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      (state_reg == OVS_LATCH && !clear_reg && want_on && was_en_reg) |=> state_reg == OVS_LATCH)
      else $error("latch left");
   a_pg_low_off: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      (state_reg != OVS_RUN) |=> !POWER_GOOD_OUTPUT.pg_o) else $error("pg high off");
   a_clamp_cap: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      init_done_reg |=> TARGET_MV <= $past(hw_cap)) else $error("clamp broken");
   a_strap_once: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      init_done_reg && $past(init_done_reg) |-> $stable(strap_reg)) else $error("strap moved");
   a_pg_od_drive: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      !fcfg_reg[FC_PUSHPULL] && pg_now |=> !POWER_GOOD_OUTPUT.pg_oe) else $error("od drove");
   a_hiccup_retry: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      (state_reg == OVS_HICC && want_on && cnt_reg == 32'(HICCUP_CYCLES - 1))
      |=> state_reg == OVS_RAMP) else $error("no retry");
endmodule

// File: testbench/ovs_front_model.sv
module ovs_front_model (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // From the supervisor
   input  wire logic        regulate,
   input  wire logic [11:0] target_mv,
   // Fault injection from the bench
   input  wire logic        force_en,
   input  wire logic [11:0] force_mv,
   // Back to the supervisor
   output logic      [11:0] sense_mv,
   output logic             ramp_done
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [2:0] ramp_cnt;

   ////////////////////////////////////////////////////////////////////////////
   // Fixed four-cycle soft ramp; restarts whenever regulation stops
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ramp_cnt <= 3'h0;
      end else if (!regulate) begin
         ramp_cnt <= 3'h0;
      end else if (ramp_cnt != 3'h4) begin
         ramp_cnt <= ramp_cnt + 3'h1;
      end
   end

   assign ramp_done = (ramp_cnt == 3'h4);
   // Output collapses to zero at once when not regulating; no pre-bias
   assign sense_mv  = force_en ? force_mv : (regulate ? target_mv : 12'h000);
endmodule

// File: testbench/test_output_voltage_supervisor.sv
`define CHK(nm, e, v) begin n_checks++; if ((v) !== (e)) begin miscompares++; \
   $display("Error %s expected %0h seen %0h", nm, e, v); end end
`define WAITF(c) begin k = 0; while ((c) !== 1'h1 && k < 50) begin \
   @(posedge clk_sys); k++; end end

module test_output_voltage_supervisor;
   import ovs_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;

   logic        clk_sys, arst_n, hsel, hwrite, hreadyout, hresp;
   logic        enable_pin, force_en, ramp_done, regulate, soft_stop;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [4:0]  strap;
   logic [11:0] sense, target, force_mv;
   ovs_pg_t     pg;
   int          miscompares, n_checks, k;
   logic [4:0]  codes [4] = '{5'h01, 5'h14, 5'h1F, 5'h00};
   logic [11:0] mvs   [4] = '{12'h258, 12'h708, 12'h4B0, 12'h3E8};
   logic [7:0]  ta [13] = '{OFS_VOUT_CMD, OFS_VOUT_TRIM, OFS_VOUT_TRIM, OFS_VOUT_CMD,
      OFS_OPERATION, OFS_OPERATION, OFS_MARGIN_HI, OFS_OPERATION, OFS_OPERATION,
      OFS_OV_LIMIT, OFS_VOUT_CMD, OFS_VOUT_MAX, OFS_VOUT_MAX};
   logic [15:0] td [13] = '{16'h044C, 16'h3FF6, 16'h0000, 16'h03E8, 16'h00A0, 16'h0090,
      16'h044C, 16'h00B0, 16'h0080, 16'h0578, 16'h0514, 16'h041A, 16'h0578};
   // FFF marks a step with nothing to compare
   logic [11:0] te [13] = '{12'h44C, 12'h442, 12'hFFF, 12'hFFF, 12'h41A, 12'h3B6,
      12'hFFF, 12'h44C, 12'hFFF, 12'hFFF, 12'h47E, 12'h41A, 12'h47E};

   ovs_top #(.HICCUP_CYCLES(20)) dut_u (
      .CLK_SYS(clk_sys), .ARST_N(arst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
      .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
      .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .ENABLE_PIN(enable_pin),
      .SETPOINT_STRAP_CODE(strap), .VOUT_SENSE_MV(sense), .RAMP_DONE(ramp_done),
      .REGULATE(regulate), .TARGET_MV(target), .SOFT_STOP(soft_stop),
      .POWER_GOOD_OUTPUT(pg));

   ovs_front_model front_u (
      .clk(clk_sys), .rst_n(arst_n), .regulate(regulate), .target_mv(target),
      .force_en(force_en), .force_mv(force_mv), .sense_mv(sense), .ramp_done(ramp_done));

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_sys = 1'h0;
      forever #50 clk_sys = ~clk_sys;
   end

   // Entered only just after a rising edge; holds each phase until hready
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel   <= 1'h1;
      htrans <= 2'h2;
      haddr  <= {24'h000000, a};
      hwrite <= w;
      do @(posedge clk_sys); while (hreadyout !== 1'h1);
      hsel   <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk_sys); while (hreadyout !== 1'h1);
      rd = hrdata;
   endtask

   task automatic do_reset(input logic [4:0] code);
      strap  <= code;
      arst_n <= 1'h0;
      repeat (5) @(posedge clk_sys);
      arst_n <= 1'h1;
      repeat (3) @(posedge clk_sys);
   endtask

   task automatic report_and_stop;
      if (miscompares == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk_sys);
      miscompares++;
      report_and_stop;
   end

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {hsel, hwrite, htrans, haddr, hwdata, enable_pin, force_en} = '0;
      {arst_n, force_mv, strap, miscompares, n_checks} = '0;
      hsize = 3'h2;
      @(posedge clk_sys);
      for (int i = 0; i < 4; i++) begin
         do_reset(codes[i]);
         enable_pin <= 1'h1;
         bus(1'h1, OFS_OPERATION, 32'h80);
         `WAITF(regulate)
         `CHK("regulate", 1'h1, regulate)
         `CHK("strap target", mvs[i], target)
         enable_pin <= 1'h0;
         repeat (4) @(posedge clk_sys);
      end
      `CHK("soft stop off", 1'h0, soft_stop)
      bus(1'h0, OFS_ONOFF_CFG, 32'h0);
      `CHK("onoff reset", 32'h7, rd)
      bus(1'h0, 8'h3C, 32'h0);
      `CHK("unmapped", 32'h0, rd)
      `CHK("okay response", 1'h0, hresp)
      bus(1'h1, OFS_PG_DELAY, 32'h8);
      strap      <= 5'h0A;
      enable_pin <= 1'h1;
      `WAITF(regulate)
      `CHK("pg in ramp", 1'h0, pg.pg_o)
      `WAITF(ramp_done)
      `WAITF(pg.pg_o)
      `CHK("pg delay", 1'h1, k >= 8 && k < 20)
      `CHK("pg open drain", 2'h2, pg)
      `CHK("strap held", MV_STRAP_SHORT, target)
      bus(1'h1, OFS_FAULT_CFG, 32'h8);
      repeat (4) @(posedge clk_sys);
      `CHK("pg push pull", 2'h3, pg)
      // Setpoint writes only while power good is up
      for (int i = 0; i < 13; i++) begin
         bus(1'h1, ta[i], {16'h0000, td[i]});
         repeat (4) @(posedge clk_sys);
         if (te[i] !== 12'hFFF) `CHK("target", te[i], target)
      end
      bus(1'h0, OFS_VOUT_CMD, 32'h0);
      `CHK("setpoint readback", 32'h514, rd)
      bus(1'h1, OFS_VOUT_CMD, 32'h3E8);
      force_en <= 1'h1;
      force_mv <= 12'h366;
      repeat (5) @(posedge clk_sys);
      `CHK("pg hysteresis", 1'h1, pg.pg_o)
      force_mv <= 12'h1F4;
      `WAITF(regulate === 1'h0)
      `CHK("uv shutdown", 1'h1, k <= 3)
      `CHK("pg in fault", 1'h0, pg.pg_o)
      force_en <= 1'h0;
      repeat (10) @(posedge clk_sys);
      `CHK("hiccup wait", 1'h0, regulate)
      `WAITF(regulate)
      `CHK("hiccup retry", 1'h1, regulate)
      bus(1'h1, OFS_FAULT_CFG, 32'h1);
      `WAITF(ramp_done)
      force_en <= 1'h1;
      force_mv <= 12'h5DC;
      `WAITF(regulate === 1'h0)
      force_en <= 1'h0;
      repeat (60) @(posedge clk_sys);
      `CHK("latched off", 1'h0, regulate)
      bus(1'h0, OFS_STATUS, 32'h0);
      `CHK("status", 8'hC4, rd[7:0])
      bus(1'h1, OFS_CLEAR, 32'h0);
      `WAITF(regulate)
      `CHK("cleared", 1'h1, regulate)
      bus(1'h1, OFS_FAULT_CFG, 32'h4);
      force_en <= 1'h1;
      `WAITF(regulate === 1'h0)
      force_en <= 1'h0;
      repeat (60) @(posedge clk_sys);
      `CHK("share latched", 1'h0, regulate)
      enable_pin <= 1'h0;
      repeat (4) @(posedge clk_sys);
      enable_pin <= 1'h1;
      `WAITF(pg.pg_o)
      `CHK("re-enabled", 1'h1, regulate)
      enable_pin <= 1'h0;
      `WAITF(regulate === 1'h0)
      `CHK("pg on disable", 1'h0, pg.pg_o)
      enable_pin <= 1'h1;
      `WAITF(regulate)
      bus(1'h1, OFS_OPERATION, 32'h0);
      `WAITF(regulate === 1'h0)
      `CHK("bus disable", 1'h0, regulate)
      bus(1'h1, OFS_ONOFF_CFG, 32'hB);
      bus(1'h1, OFS_OPERATION, 32'h80);
      enable_pin <= 1'h0;
      `WAITF(regulate)
      `CHK("active low pin", 1'h1, regulate)
      enable_pin <= 1'h1;
      `WAITF(soft_stop)
      `CHK("soft stop", 1'h1, soft_stop)
      report_and_stop;
   end
endmodule
